// ### ccsw_pkg.sv
// ccsw_pkg: register map, field positions, reset values and codes for the
// machine-cycle clock divider with hardware switchback.
// assumes byte-wide special-register accesses from the core, one clock domain.
package ccsw_pkg;

  // special-register addresses
  localparam logic [7:0] ADDR_EXT_FLAG    = 8'h91; // external_flag_clock_select
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'hc4; // power_management_control
  localparam logic [7:0] ADDR_SVC_STATUS  = 8'hc5; // service_and_serial_activity

  // power_management_control fields
  localparam int POS_DIV_HI     = 7;  // divider_sel_hi
  localparam int POS_DIV_LO     = 6;  // divider_sel_lo
  localparam int POS_SWB_EN     = 5;  // switchback_enable
  localparam int POS_AMP_OFF    = 3;  // crystal_amp_disable

  // external_flag_clock_select fields
  localparam int POS_SRC_XTAL   = 3;  // source_select_crystal
  localparam int POS_RING_ACT   = 2;  // ring_active_flag

  // service_and_serial_activity fields
  localparam int POS_PF_LEVEL   = 7;
  localparam int POS_HI_LEVEL   = 6;
  localparam int POS_LO_LEVEL   = 5;
  localparam int POS_XT_READY   = 4;
  localparam int POS_P1_TX      = 3;
  localparam int POS_P1_RX      = 2;
  localparam int POS_P0_TX      = 1;
  localparam int POS_P0_RX      = 0;

  // divider codes
  localparam logic [1:0] DIV_CODE_RSVD = 2'h0;
  localparam logic [1:0] DIV_CODE_4    = 2'h1;
  localparam logic [1:0] DIV_CODE_64   = 2'h2;
  localparam logic [1:0] DIV_CODE_1024 = 2'h3;

  // last count of the source-clock prescaler for each rate
  localparam logic [9:0] DIV_LAST_4    = 10'h003;
  localparam logic [9:0] DIV_LAST_64   = 10'h03f;
  localparam logic [9:0] DIV_LAST_1024 = 10'h3ff;

  // reset values
  localparam logic [1:0] RST_DIV_CODE  = DIV_CODE_4;
  localparam logic       RST_SWB_EN    = 1'b0;
  localparam logic       RST_AMP_OFF   = 1'b0;
  localparam logic       RST_SRC_XTAL  = 1'b1;
  localparam logic       RST_RING_ACT  = 1'b0;
  localparam logic       RST_XT_READY  = 1'b1;

  // machine cycles between an accepted divider or source write and its effect
  localparam logic [1:0] APPLY_DELAY_MC = 2'h2;

  // crystal clocks of warm-up after the amplifier is re-enabled
  localparam int unsigned XTAL_WARM_CLKS = 65536;

  // number of external interrupt sources and serial ports
  localparam int NUM_EXT_IRQ = 6;
  localparam int NUM_SERIAL  = 2;

  // crystal warm-up states
  typedef enum logic [2:0] {
    CCSW_XT_RUN  = 3'b001,
    CCSW_XT_OFF  = 3'b010,
    CCSW_XT_WARM = 3'b100
  } ccsw_xt_state_t;

endpackage

// ### ccsw_mcdiv.sv
// ccsw_mcdiv: prescaler turning source-clock ticks into machine-cycle ticks.
// assumes src_tick is a one-cycle pulse per selected oscillator clock.
`timescale 1ns/1ns
module ccsw_mcdiv
  import ccsw_pkg::*;
(
  input  wire logic       clock,    // system clock
  input  wire logic       resetn,   // synchronous reset, active low
  input  wire logic       clk_en,   // freezes all state while low
  input  wire logic       src_tick, // one oscillator clock has elapsed
  input  wire logic [1:0] code,     // active divider code
  output logic            mc_tick   // one machine cycle has elapsed
);
  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } ccsw_div_state_t;

  ccsw_div_state_t st_reg;
  ccsw_div_state_t st_next;
  logic [9:0]      last;

  always_comb begin
    case (code)
      DIV_CODE_64:   last = DIV_LAST_64;
      DIV_CODE_1024: last = DIV_LAST_1024;
      default:       last = DIV_LAST_4;
    endcase
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (src_tick) begin
      // a rate drop below the current count wraps at once instead of running to 1023
      if (st_reg.cnt >= last) begin
        st_next.cnt  = 10'h000;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign mc_tick = st_reg.tick;
endmodule

// ### ccsw_clkctl.sv
// ccsw_clkctl: machine-cycle rate control, switchback, clock source and status.
// assumes the core presents byte special-register accesses and synchronous event pulses.
// Function
// (R1) divider code 01 = 4 clocks, 10 = 64, 11 = 1024; 00 reserved
// (R2) new divider rate takes effect after one more instruction cycle
// (R3) machine-cycle tick drives cpu, timers and serial baud alike
// (R4) 64 or 1024 may be selected only from the 4-clock rate
// (R5) hardware never enters a reduced rate by itself
// (R6) automatic return to 4 clocks only while switchback enable is set
// (R7) enabled valid external interrupt forces divider back to 4 clocks
// (R8) external interrupt wakes only if its priority could be taken now
// (R9) start-bit edge on enabled receiver restores the 4-clock rate
// (R10) write to either transmit buffer restores the 4-clock rate
// (R11) start-bit detection raises no interrupt, only switchback
// (R12) ring or crystal source both feed the same divider
// (R13) status 7..5 show power-fail, high, low level in service
// (R14) status 0/1 show port 0 receive and transmit activity
// (R15) status 2/3 show port 1 receive and transmit activity
// (R16) software checks serial activity clear before slowing down
// (R17) software exits by writing 4-clock code, then crystal source
// (R18) software checks service level before entering reduced rate
// (R19) software may enter low level service to block low wakeups
// (R20) software sets divider, then ring, then disables crystal
// (R21) flag bit 3 selects crystal, bit 2 reports ring active
// (R22) crystal amplifier disable settable only while ring selected
// (R23) crystal ready after warm-up count; crystal select blocked until then
// (R24) switchback leaves the clock source untouched
// (R25) reserved or illegal divider writes are ignored
// (R26) switchback beats a simultaneous software divider write
`timescale 1ns/1ns
module ccsw_clkctl
  import ccsw_pkg::*;
#(
  parameter int unsigned WARM_CLKS = XTAL_WARM_CLKS
)(
  input  wire logic                   clock,         // system clock, 250 MHz
  input  wire logic                   resetn,        // synchronous reset, active low
  input  wire logic                   clk_en,        // freezes all state while low
  input  wire logic [7:0]             sfr_addr,      // special-register address
  input  wire logic                   sfr_wr,        // write strobe
  input  wire logic [7:0]             sfr_wdata,     // write data
  input  wire logic                   sfr_rd,        // read strobe
  output logic      [7:0]             sfr_rdata,     // read data, one cycle after sfr_rd
  input  wire logic                   xtal_tick,     // one crystal clock elapsed
  input  wire logic                   ring_tick,     // one ring clock elapsed
  input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_req,   // enabled external source requesting
  input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_high,  // source set to high priority
  input  wire logic                   pf_in_service, // power-fail level in service
  input  wire logic                   hi_in_service, // high level in service
  input  wire logic                   lo_in_service, // low level in service
  input  wire logic [NUM_SERIAL-1:0]  rx_enable,     // receiver enabled per port
  input  wire logic [NUM_SERIAL-1:0]  rx_start_edge, // start-bit leading edge per port
  input  wire logic [NUM_SERIAL-1:0]  tx_buf_write,  // transmit buffer written per port
  input  wire logic [NUM_SERIAL-1:0]  rx_busy,       // word being received per port
  input  wire logic [NUM_SERIAL-1:0]  tx_busy,       // transmission shifting per port
  output logic                        mc_tick,       // machine-cycle enable for all units
  output logic      [1:0]             rate_code,     // divider code now in force
  output logic                        ring_select,   // clock taken from the ring
  output logic                        crystal_amp_disable // crystal amplifier off
);
  typedef struct packed {
    logic [1:0]     div_code;
    logic [1:0]     act_code;
    logic [1:0]     div_wait;
    logic           swb_en;
    logic           amp_off;
    logic           src_xtal;
    logic           ring_act;
    logic [1:0]     src_wait;
    logic           xt_ready;
    ccsw_xt_state_t xt_state;
    logic [15:0]    xt_cnt;
    logic [7:0]     rdata;
  } ccsw_state_t;

  localparam logic [15:0] WARM_LAST = 16'(WARM_CLKS - 1);

  ccsw_state_t            st_reg;
  ccsw_state_t            st_next;
  logic                   div_tick;
  logic                   src_tick;
  logic [1:0]             wr_code;
  logic                   wr_pmr;
  logic                   wr_external_flag_clock_select;
  logic                   code_ok;
  logic                   ext_wake;
  logic                   sb_event;
  logic [NUM_SERIAL-1:0]  ser_wake;
  logic [NUM_EXT_IRQ-1:0] irq_takeable;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // the selected source feeds one prescaler for every rate
  assign src_tick = st_reg.ring_act ? ring_tick : xtal_tick; // R12

  ccsw_mcdiv u_div (
    .clock    (clock),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .src_tick (src_tick),
    .code     (st_reg.act_code),
    .mc_tick  (div_tick)
  );

  // a source may wake only if the controller could take it at this moment
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT_IRQ; gi++) begin : g_irq
      assign irq_takeable[gi] = ext_irq_req[gi] && !pf_in_service && !hi_in_service &&
                                (ext_irq_high[gi] || !lo_in_service); // R8
    end
    for (gi = 0; gi < NUM_SERIAL; gi++) begin : g_ser
      // start edge only wakes the rate; the receive interrupt stays with the port
      assign ser_wake[gi] = (rx_enable[gi] && rx_start_edge[gi]) || tx_buf_write[gi]; // R9 R10 R11
    end
  endgenerate

  assign ext_wake = |irq_takeable; // R7
  assign sb_event = st_reg.swb_en && (ext_wake || (|ser_wake)); // R6
  assign wr_pmr   = sfr_wr && hit(sfr_addr, ADDR_POWER_CTRL);
  assign wr_external_flag_clock_select  = sfr_wr && hit(sfr_addr, ADDR_EXT_FLAG);
  assign wr_code  = {sfr_wdata[POS_DIV_HI], sfr_wdata[POS_DIV_LO]};
  // reduced rates only while 4 clocks is both stored and running; a pending return
  // from one reduced rate must not be turned straight into the other
  assign code_ok  = (wr_code == DIV_CODE_4) ||
                    ((wr_code != DIV_CODE_RSVD) && (st_reg.div_code == DIV_CODE_4) &&
                     (st_reg.act_code == DIV_CODE_4)); // R4 R25

  always_comb begin
    st_next = st_reg;

    // divider field: only software enters a reduced rate
    if (sb_event) begin
      st_next.div_code = DIV_CODE_4; // R7 R26
      st_next.act_code = DIV_CODE_4;
      st_next.div_wait = 2'h0;
    end else if (wr_pmr && code_ok) begin
      st_next.div_code = wr_code; // R1 R5
      st_next.div_wait = APPLY_DELAY_MC;
    end else if (div_tick && (st_reg.div_wait != 2'h0)) begin
      // second machine-cycle tick after the write: one full cycle has passed
      st_next.div_wait = st_reg.div_wait - 2'h1;
      if (st_reg.div_wait == 2'h1) begin
        st_next.act_code = st_reg.div_code; // R2
      end
    end

    if (wr_pmr) begin
      st_next.swb_en = sfr_wdata[POS_SWB_EN];
      if (!sfr_wdata[POS_AMP_OFF]) begin
        st_next.amp_off = 1'b0;
      end else if (!st_reg.src_xtal) begin
        st_next.amp_off = 1'b1; // R22
      end
    end

    // source select follows software only; switchback never touches it
    if (wr_external_flag_clock_select) begin
      if (!sfr_wdata[POS_SRC_XTAL]) begin
        st_next.src_xtal = 1'b0; // R21
        st_next.src_wait = APPLY_DELAY_MC;
      end else if (st_reg.xt_ready && !st_reg.amp_off) begin
        st_next.src_xtal = 1'b1; // R23
        st_next.src_wait = APPLY_DELAY_MC;
      end
    end else if (div_tick && (st_reg.src_wait != 2'h0)) begin
      st_next.src_wait = st_reg.src_wait - 2'h1;
      if (st_reg.src_wait == 2'h1) begin
        st_next.ring_act = !st_reg.src_xtal; // R21 R24
      end
    end

    // crystal warm-up after the amplifier is re-enabled
    case (st_reg.xt_state)
      CCSW_XT_RUN: begin
        if (st_next.amp_off) begin
          st_next.xt_state = CCSW_XT_OFF;
          st_next.xt_ready = 1'b0;
        end
      end
      CCSW_XT_OFF: begin
        if (!st_next.amp_off) begin
          st_next.xt_state = CCSW_XT_WARM;
          st_next.xt_cnt   = 16'h0000;
        end
      end
      CCSW_XT_WARM: begin
        if (st_next.amp_off) begin
          st_next.xt_state = CCSW_XT_OFF;
        end else if (xtal_tick) begin
          if (st_reg.xt_cnt == WARM_LAST) begin
            st_next.xt_state = CCSW_XT_RUN;
            st_next.xt_ready = 1'b1; // R23
          end else begin
            st_next.xt_cnt = st_reg.xt_cnt + 16'h0001;
          end
        end
      end
      default: begin
        st_next.xt_state = CCSW_XT_RUN;
      end
    endcase

    // register read; unowned bits read zero
    if (sfr_rd) begin
      st_next.rdata = 8'h00;
      if (hit(sfr_addr, ADDR_POWER_CTRL)) begin
        st_next.rdata[POS_DIV_HI]  = st_reg.div_code[1];
        st_next.rdata[POS_DIV_LO]  = st_reg.div_code[0];
        st_next.rdata[POS_SWB_EN]  = st_reg.swb_en;
        st_next.rdata[POS_AMP_OFF] = st_reg.amp_off;
      end else if (hit(sfr_addr, ADDR_EXT_FLAG)) begin
        st_next.rdata[POS_SRC_XTAL] = st_reg.src_xtal;
        st_next.rdata[POS_RING_ACT] = st_reg.ring_act;
      end else if (hit(sfr_addr, ADDR_SVC_STATUS)) begin
        st_next.rdata[POS_PF_LEVEL] = pf_in_service; // R13
        st_next.rdata[POS_HI_LEVEL] = hi_in_service;
        st_next.rdata[POS_LO_LEVEL] = lo_in_service;
        st_next.rdata[POS_XT_READY] = st_reg.xt_ready;
        st_next.rdata[POS_P0_RX]    = rx_busy[0]; // R14
        st_next.rdata[POS_P0_TX]    = tx_busy[0];
        st_next.rdata[POS_P1_RX]    = rx_busy[1]; // R15
        st_next.rdata[POS_P1_TX]    = tx_busy[1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_reg          <= '0;
      st_reg.div_code <= RST_DIV_CODE;
      st_reg.act_code <= RST_DIV_CODE;
      st_reg.swb_en   <= RST_SWB_EN;
      st_reg.amp_off  <= RST_AMP_OFF;
      st_reg.src_xtal <= RST_SRC_XTAL;
      st_reg.ring_act <= RST_RING_ACT;
      st_reg.xt_ready <= RST_XT_READY;
      st_reg.xt_state <= CCSW_XT_RUN;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign mc_tick             = div_tick; // R3
  assign rate_code           = st_reg.act_code;
  assign ring_select         = st_reg.ring_act;
  assign crystal_amp_disable = st_reg.amp_off;
  assign sfr_rdata           = st_reg.rdata;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_code_legal;
    (st_reg.div_code != DIV_CODE_RSVD) && (st_reg.act_code != DIV_CODE_RSVD);
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("reserved divider code held"); // R1

  property p_apply_delay;
    (clk_en && wr_pmr && code_ok && !sb_event && (wr_code != st_reg.act_code))
      |=> (st_reg.act_code == $past(st_reg.act_code));
  endproperty
  a_apply_delay: assert property (p_apply_delay) else $error("rate applied without delay"); // R2

  property p_no_cross;
    (clk_en && st_reg.div_code[1] && wr_pmr && (wr_code != st_reg.div_code) && !sb_event)
      |=> (st_reg.div_code == $past(st_reg.div_code)) || (st_reg.div_code == DIV_CODE_4);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("direct reduced-rate change"); // R4

  property p_no_self_entry;
    (st_reg.div_code == DIV_CODE_4) && !(clk_en && wr_pmr) |=> (st_reg.div_code == DIV_CODE_4);
  endproperty
  a_no_self_entry: assert property (p_no_self_entry) else $error("hardware entered reduced rate"); // R5

  property p_swb_gate;
    !st_reg.swb_en && !wr_pmr |=> $stable(st_reg.div_code);
  endproperty
  a_swb_gate: assert property (p_swb_gate) else $error("switchback while disabled"); // R6

  property p_ext_wake;
    (clk_en && st_reg.swb_en && ext_wake) |=> (st_reg.div_code == DIV_CODE_4) &&
                                              (st_reg.act_code == DIV_CODE_4);
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("external wake missed"); // R7

  property p_blocked_ext;
    (hi_in_service && ((ext_irq_req & ext_irq_high) == '0) && (ser_wake == '0) && !wr_pmr)
      |=> $stable(st_reg.div_code);
  endproperty
  a_blocked_ext: assert property (p_blocked_ext) else $error("blocked source woke divider"); // R8

  property p_ser_wake;
    (clk_en && st_reg.swb_en && (|((rx_enable & rx_start_edge) | tx_buf_write)))
      |=> (st_reg.div_code == DIV_CODE_4);
  endproperty
  a_ser_wake: assert property (p_ser_wake) else $error("serial wake missed"); // R9

  property p_status_read;
    (clk_en && sfr_rd && hit(sfr_addr, ADDR_SVC_STATUS)) |=>
      (sfr_rdata[7:5] == $past({pf_in_service, hi_in_service, lo_in_service})) &&
      (sfr_rdata[3:0] == $past({tx_busy[1], rx_busy[1], tx_busy[0], rx_busy[0]}));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // R13

  property p_amp_guard;
    (clk_en && wr_pmr && sfr_wdata[POS_AMP_OFF] && st_reg.src_xtal && !st_reg.amp_off)
      |=> !st_reg.amp_off;
  endproperty
  a_amp_guard: assert property (p_amp_guard) else $error("amp disabled on crystal"); // R22

  property p_xtal_block;
    (clk_en && wr_external_flag_clock_select && sfr_wdata[POS_SRC_XTAL] && !st_reg.xt_ready && !st_reg.src_xtal)
      |=> !st_reg.src_xtal;
  endproperty
  a_xtal_block: assert property (p_xtal_block) else $error("crystal selected before ready"); // R23

  property p_swb_keeps_src;
    sb_event && !wr_external_flag_clock_select |=> $stable(st_reg.src_xtal);
  endproperty
  a_swb_keeps_src: assert property (p_swb_keeps_src) else $error("switchback moved source"); // R24
endmodule

// ### ccsw_osc_model.sv
// ccsw_osc_model: crystal and ring tick source on the far side of the divider.
// assumes the bench clock; ticks change on its falling edge like bench inputs.
`timescale 1ns/1ns
module ccsw_osc_model #(
  parameter int XT_DIV = 2,
  parameter int RG_DIV = 3
)(
  input  wire logic clock,            // bench clock
  output logic      xtal_tick = 1'b0, // one crystal clock elapsed
  output logic      ring_tick = 1'b0  // one ring clock elapsed
);
  int xt_cnt = 0;
  int rg_cnt = 0;

  // both oscillators run free; the controller's source select alone decides which one counts
  always @(negedge clock) begin
    xt_cnt    <= (xt_cnt + 1) % XT_DIV;
    rg_cnt    <= (rg_cnt + 1) % RG_DIV;
    xtal_tick <= (xt_cnt == XT_DIV - 1);
    ring_tick <= (rg_cnt == RG_DIV - 1);
  end
endmodule

// ### tb.sv
// tb: self-checking bench for ccsw_clkctl, register reads checked from a queue.
// assumes ccsw_osc_model ticks the crystal every 2 cycles and the ring every 3.
`timescale 1ns/1ns
module tb;
  import ccsw_pkg::*;
  localparam int WARM = 16;
  logic                   clock     = 1'b0;
  logic                   resetn    = 1'b0;
  logic                   clk_en    = 1'b1;
  logic [7:0]             sfr_addr  = 8'h00;
  logic [7:0]             sfr_wdata = 8'h00;
  logic                   sfr_wr    = 1'b0;
  logic                   sfr_rd    = 1'b0;
  logic                   rd_taken  = 1'b0;
  logic [NUM_EXT_IRQ-1:0] irq_req   = '0;
  logic [NUM_EXT_IRQ-1:0] irq_high  = '0;
  logic                   pf = 1'b0, hi = 1'b0, lo = 1'b0;
  logic [1:0]             rx_en = 2'h0, rx_edge = 2'h0, tx_wr = 2'h0;
  logic [1:0]             rx_busy = 2'h0, tx_busy = 2'h0;
  logic [7:0]             sfr_rdata;
  logic                   xtal_tick, ring_tick, mc_tick, ring_select, amp_off;
  logic [1:0]             rate_code;
  logic [7:0]             exp_q[$];
  int                     err_count = 0, num_checks = 0, cycles = 0;

  always #2 clock = ~clock;

  ccsw_osc_model osc (.clock(clock), .xtal_tick(xtal_tick), .ring_tick(ring_tick));

  ccsw_clkctl #(.WARM_CLKS(WARM)) DUT (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .xtal_tick(xtal_tick), .ring_tick(ring_tick), .ext_irq_req(irq_req),
    .ext_irq_high(irq_high), .pf_in_service(pf), .hi_in_service(hi),
    .lo_in_service(lo), .rx_enable(rx_en), .rx_start_edge(rx_edge),
    .tx_buf_write(tx_wr), .rx_busy(rx_busy), .tx_busy(tx_busy), .mc_tick(mc_tick),
    .rate_code(rate_code), .ring_select(ring_select), .crystal_amp_disable(amp_off)
  );

  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask

  // read data is judged by the watcher on the falling edge half a cycle after the taken edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    exp_q.push_back(e);
    @(negedge clock);
    sfr_rd = 1'b0;
  endtask

  always @(posedge clock) rd_taken <= sfr_rd & clk_en;
  always @(negedge clock) begin
    if (rd_taken) begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(sfr_rdata, exp_q.pop_front());
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      final_report();
    end
  end

  // leaving the 1024-clock rate takes two slow machine cycles, over 4000 clocks
  task automatic wait_rate(input logic [1:0] c);
    for (int n = 0; n < 5000 && rate_code !== c; n++) @(negedge clock);
    chk(rate_code, c);
  endtask

  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (mc_tick !== 1'b1 && n < 5000);
  endtask

  // the first interval after a rate change may be partial, so skip two ticks and time the third
  task automatic measure(input int exp);
    int n;
    n = 0;
    wait_tick();
    wait_tick();
    do begin
      @(negedge clock);
      n++;
    end while (mc_tick !== 1'b1 && n < 5000);
    chk(n, exp);
  endtask

  task automatic ev(input int kind, input int idx);
    @(negedge clock);
    case (kind)
      0: irq_req[idx] = 1'b1;
      1: rx_edge[idx] = 1'b1;
      default: tx_wr[idx] = 1'b1;
    endcase
    @(negedge clock);
    irq_req = '0;
    rx_edge = 2'h0;
    tx_wr   = 2'h0;
  endtask

  task automatic sw_case(input int kind, input int idx, input logic take);
    wr(ADDR_POWER_CTRL, 8'ha0);
    wait_rate(DIV_CODE_64);
    ev(kind, idx);
    chk(rate_code, take ? DIV_CODE_4 : DIV_CODE_64);
    rd(ADDR_POWER_CTRL, take ? 8'h60 : 8'ha0);
  endtask

  initial begin
    void'($urandom(66313));
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    clk_en = 1'b0;
    repeat (4) @(negedge clock);
    clk_en = 1'b1;
    rd(ADDR_POWER_CTRL, 8'h40);
    rd(ADDR_EXT_FLAG, 8'h08);
    rd(ADDR_SVC_STATUS, 8'h10);
    rd(8'h00, 8'h00);
    wr(ADDR_SVC_STATUS, 8'hff);
    for (int i = 0; i < 6; i++) begin
      {pf, hi, lo, rx_busy, tx_busy} = 7'($urandom);
      rd(ADDR_SVC_STATUS, {pf, hi, lo, 1'b1, tx_busy[1], rx_busy[1], tx_busy[0], rx_busy[0]});
    end
    {pf, hi, lo, rx_busy, tx_busy} = 7'h00;
    chk(rate_code, DIV_CODE_4);
    measure(8);
    wr(ADDR_POWER_CTRL, 8'h80);
    wait_tick();
    chk(rate_code, DIV_CODE_4);
    wait_rate(DIV_CODE_64);
    measure(128);
    wr(ADDR_POWER_CTRL, 8'hc0);
    rd(ADDR_POWER_CTRL, 8'h80);
    wr(ADDR_POWER_CTRL, 8'h40);
    wait_rate(DIV_CODE_4);
    wr(ADDR_POWER_CTRL, 8'h00);
    rd(ADDR_POWER_CTRL, 8'h40);
    wr(ADDR_POWER_CTRL, 8'hc0);
    wait_rate(DIV_CODE_1024);
    measure(2048);
    wr(ADDR_POWER_CTRL, 8'h40);
    wr(ADDR_POWER_CTRL, 8'h80);
    rd(ADDR_POWER_CTRL, 8'h40);
    wait_rate(DIV_CODE_4);
    wr(ADDR_POWER_CTRL, 8'h80);
    wait_rate(DIV_CODE_64);
    rx_en = 2'h3;
    ev(0, 0);
    ev(1, 0);
    ev(2, 1);
    chk(rate_code, DIV_CODE_64);
    for (int k = 0; k < 16; k++) begin
      irq_high = NUM_EXT_IRQ'($urandom);
      {pf, hi, lo, irq_high[k % 6]} = k[3:0];
      sw_case(0, k % 6, !k[3] && !k[2] && (k[0] || !k[1]));
    end
    {pf, hi, lo} = 3'h0;
    sw_case(2, 0, 1'b1);
    sw_case(2, 1, 1'b1);
    rx_en = 2'h2;
    sw_case(1, 0, 1'b0);
    sw_case(1, 1, 1'b1);
    // a legal slow-down written in the same cycle as a wake event
    @(negedge clock);
    sfr_addr  = ADDR_POWER_CTRL;
    sfr_wdata = 8'ha0;
    sfr_wr    = 1'b1;
    tx_wr     = 2'h1;
    @(negedge clock);
    sfr_wr = 1'b0;
    tx_wr  = 2'h0;
    repeat (40) @(negedge clock);
    chk(rate_code, DIV_CODE_4);
    rd(ADDR_POWER_CTRL, 8'h60);
    wr(ADDR_POWER_CTRL, 8'h68);
    rd(ADDR_POWER_CTRL, 8'h60);
    wr(ADDR_EXT_FLAG, 8'h00);
    for (int n = 0; n < 3000 && ring_select !== 1'b1; n++) @(negedge clock);
    rd(ADDR_EXT_FLAG, 8'h04);
    measure(12);
    wr(ADDR_POWER_CTRL, 8'ha0);
    wait_rate(DIV_CODE_64);
    ev(2, 0);
    chk(rate_code, DIV_CODE_4);
    chk(ring_select, 1'b1);
    wr(ADDR_POWER_CTRL, 8'h68);
    chk(amp_off, 1'b1);
    rd(ADDR_SVC_STATUS, 8'h00);
    wr(ADDR_EXT_FLAG, 8'h08);
    rd(ADDR_EXT_FLAG, 8'h04);
    wr(ADDR_POWER_CTRL, 8'h60);
    repeat (20) @(negedge clock);
    rd(ADDR_SVC_STATUS, 8'h00);
    repeat (40) @(negedge clock);
    rd(ADDR_SVC_STATUS, 8'h10);
    wr(ADDR_EXT_FLAG, 8'h08);
    for (int n = 0; n < 3000 && ring_select !== 1'b0; n++) @(negedge clock);
    rd(ADDR_EXT_FLAG, 8'h08);
    repeat (4) @(negedge clock);
    final_report();
  end
endmodule
